// ### rtl/vobc_top.sv
/*
 Capacitor bank switching control: pushbutton routing, safety interlock,
 voltage override state machine, AXI4-Lite registers and interrupt.
 Assumes line voltage and remote strobes arrive on the core clock.
*/
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module vobc_top #(
   parameter int unsigned P_CYC_PER_MS = vobc_pkg::CYC_PER_MS
) (
   // Clock and reset
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst,
   // AXI4-Lite slave
   input  wire logic [7:0]           i_axi_awaddr,
   input  wire logic                 i_axi_awvalid,
   output var  logic                 o_axi_awready,
   input  wire logic [31:0]          i_axi_wdata,
   input  wire logic [3:0]           i_axi_wstrb,
   input  wire logic                 i_axi_wvalid,
   output var  logic                 o_axi_wready,
   output var  logic [1:0]           o_axi_bresp,
   output var  logic                 o_axi_bvalid,
   input  wire logic                 i_axi_bready,
   input  wire logic [7:0]           i_axi_araddr,
   input  wire logic                 i_axi_arvalid,
   output var  logic                 o_axi_arready,
   output var  logic [31:0]          o_axi_rdata,
   output var  logic [1:0]           o_axi_rresp,
   output var  logic                 o_axi_rvalid,
   input  wire logic                 i_axi_rready,
   // Pins and measurements
   input  wire vobc_pkg::vobc_pins_t i_pins,
   input  wire logic [15:0]          i_line_volt,
   input  wire vobc_pkg::vobc_rcmd_t i_rcmd,
   // Relay drive and status
   output var  logic                 o_close_relay,
   output var  logic                 o_trip_relay,
   output var  vobc_pkg::vobc_mode_t o_mode,
   output var  logic                 o_irq
);
   import vobc_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   vobc_pins_t pins_s;
   logic       pb_close_d_reg;
   logic       pb_trip_d_reg;

   vobc_sync #(.W(PINS_W)) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_d        (i_pins),
      .o_q        (pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes
   logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic        aw_got_reg, w_got_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0]  wstrb_reg;
   logic [1:0]  bresp_reg, rresp_reg;

   wire         aw_hs   = i_axi_awvalid & awready_reg;
   wire         w_hs    = i_axi_wvalid & wready_reg;
   wire         ar_hs   = i_axi_arvalid & arready_reg;
   wire         aw_have = aw_got_reg | aw_hs;
   wire         w_have  = w_got_reg | w_hs;
   wire         do_wr   = aw_have & w_have;
   wire [7:0]   wr_addr = aw_hs ? i_axi_awaddr : awaddr_reg;
   wire [31:0]  wr_data = w_hs ? i_axi_wdata : wdata_reg;
   wire [3:0]   wr_strb = w_hs ? i_axi_wstrb : wstrb_reg;
   wire         aw_got_next = aw_have & ~do_wr;
   wire         w_got_next  = w_have & ~do_wr;
   wire         bvalid_next = do_wr | (bvalid_reg & ~i_axi_bready);
   wire         rvalid_next = ar_hs | (rvalid_reg & ~i_axi_rready);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file
   logic              run_reg, permit_reg;
   logic [31:0]       swdly_reg, il_ms_reg;
   logic [15:0]       thr_reg [0:3];
   logic [15:0]       cpulse_ms_reg, tpulse_ms_reg;
   logic [IRQ_W-1:0]  irq_stat_reg, irq_mask_reg;
   logic [3:0]        wr_thr;

   wire wr_ctrl   = do_wr & (wr_addr == ADDR_CTRL) & wr_strb[0];
   wire wr_swdly  = do_wr & (wr_addr == ADDR_SWDLY);
   wire wr_il     = do_wr & (wr_addr == ADDR_IL_MS);
   wire wr_cpulse = do_wr & (wr_addr == ADDR_CPULSE);
   wire wr_tpulse = do_wr & (wr_addr == ADDR_TPULSE);
   wire wr_irq_st = do_wr & (wr_addr == ADDR_IRQ_ST) & wr_strb[0];
   wire wr_irq_mk = do_wr & (wr_addr == ADDR_IRQ_MK) & wr_strb[0];
   wire wr_hit    = wr_ctrl | wr_swdly | wr_il | wr_cpulse | wr_tpulse | wr_irq_st
                  | wr_irq_mk | (|wr_thr) | (do_wr & ~(|wr_strb));

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wr_thr[i] = do_wr & (wr_addr == ADDR_THR0 + 8'(4 * i));
      end
   end

   // Remote override codes
   wire rem_on   = i_rcmd.ovr_on & permit_reg;
   wire rem_off  = i_rcmd.ovr_off & permit_reg;
   wire run_next = wr_ctrl ? wr_data[CTRL_RUN_BIT] : rem_on ? 1'b1 : rem_off ? 1'b0 : run_reg;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         run_reg              <= RST_RUN;
         permit_reg           <= RST_PERMIT;
         swdly_reg            <= RST_SWDLY;
         il_ms_reg            <= RST_IL_MS;
         cpulse_ms_reg        <= RST_CPULSE;
         tpulse_ms_reg        <= RST_TPULSE;
         irq_mask_reg         <= '0;
         thr_reg[THR_TRIP]    <= RST_TRIP;
         thr_reg[THR_TREL]    <= RST_TREL;
         thr_reg[THR_CREL]    <= RST_CREL;
         thr_reg[THR_CLOSE]   <= RST_CLOSE;
      end else begin
         run_reg <= run_next;
         if (wr_ctrl) permit_reg <= wr_data[CTRL_PERMIT_BIT];
         if (wr_swdly) swdly_reg <= merge(swdly_reg, wr_data, wr_strb);
         if (wr_il) il_ms_reg <= merge(il_ms_reg, wr_data, wr_strb);
         if (wr_cpulse) cpulse_ms_reg <= 16'(merge(32'(cpulse_ms_reg), wr_data, wr_strb));
         if (wr_tpulse) tpulse_ms_reg <= 16'(merge(32'(tpulse_ms_reg), wr_data, wr_strb));
         if (wr_irq_mk) irq_mask_reg <= wr_data[IRQ_W-1:0];
         for (int i = 0; i < 4; i++) begin
            if (wr_thr[i]) thr_reg[i] <= 16'(merge(32'(thr_reg[i]), wr_data, wr_strb));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Millisecond tick
   logic [15:0] tick_cnt_reg;
   wire         ms_tick = (tick_cnt_reg == 16'(P_CYC_PER_MS - 1));

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) tick_cnt_reg <= '0;
      else tick_cnt_reg <= ms_tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Voltage override state machine
   vobc_mode_t  mode_reg, mode_next;
   vobc_rgn_t   rgn, rgn_reg;
   logic [31:0] dly_cnt_reg;

   wire above_trip  = i_line_volt > thr_reg[THR_TRIP];
   wire below_trel  = i_line_volt < thr_reg[THR_TREL];
   wire above_crel  = i_line_volt > thr_reg[THR_CREL];
   wire below_close = i_line_volt < thr_reg[THR_CLOSE];
   wire expire      = (rgn != VOBC_RGN_NONE) & (rgn == rgn_reg) & (dly_cnt_reg > swdly_reg);

   always_comb begin
      rgn       = VOBC_RGN_NONE;
      mode_next = mode_reg;
      unique case (mode_reg)
         VOBC_REMOTE: begin
            rgn = above_trip ? VOBC_RGN_UP : below_close ? VOBC_RGN_DOWN : VOBC_RGN_NONE;
            if (expire && rgn == VOBC_RGN_UP) mode_next = VOBC_TRIPPED;
            if (expire && rgn == VOBC_RGN_DOWN) mode_next = VOBC_CLOSED;
         end
         VOBC_TRIPPED: begin
            rgn = below_trel ? VOBC_RGN_DOWN : VOBC_RGN_NONE;
            if (expire) mode_next = VOBC_REMOTE;
         end
         VOBC_CLOSED: begin
            rgn = above_crel ? VOBC_RGN_UP : VOBC_RGN_NONE;
            if (expire) mode_next = VOBC_REMOTE;
         end
         default: mode_next = VOBC_REMOTE;
      endcase
      if (!run_reg) begin
         rgn       = VOBC_RGN_NONE;
         mode_next = VOBC_REMOTE;
      end
   end

   wire        tmr_clr  = (rgn != rgn_reg) | (rgn == VOBC_RGN_NONE) | (mode_next != mode_reg);
   wire        auto_trip  = run_reg & (mode_reg == VOBC_REMOTE) & (mode_next == VOBC_TRIPPED);
   wire        auto_close = run_reg & (mode_reg == VOBC_REMOTE) & (mode_next == VOBC_CLOSED);

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg    <= VOBC_REMOTE;
         rgn_reg     <= VOBC_RGN_NONE;
         dly_cnt_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         rgn_reg  <= rgn;
         if (tmr_clr) dly_cnt_reg <= '0;
         else if (ms_tick && dly_cnt_reg != 32'hFFFFFFFF) dly_cnt_reg <= dly_cnt_reg + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Relay command sources and interlock
   logic [31:0] il_cnt_reg;
   logic [15:0] close_cnt_reg, trip_cnt_reg;

   wire il_active    = il_cnt_reg != 32'h0;
   wire pb_close_blk = il_active & pins_s.interlock_select_header;
   wire close_fit    = pins_s.local_close_source_select;
   wire trip_fit     = pins_s.local_trip_source_select;
   wire pb_close_rise = pins_s.pb_close & ~pb_close_d_reg;
   wire pb_trip_rise  = pins_s.pb_trip & ~pb_trip_d_reg;
   wire rem_ok       = mode_reg == VOBC_REMOTE;
   wire rem_trip     = i_rcmd.trip & rem_ok;
   wire rem_close    = i_rcmd.close & rem_ok & ~il_active;
   wire close_load   = (~close_fit & pb_close_rise & ~pb_close_blk)
                     | rem_close | (auto_close & ~il_active);
   wire trip_load    = (~trip_fit & pb_trip_rise) | rem_trip | auto_trip;

   wire [15:0] close_cnt_next = close_load ? cpulse_ms_reg :
                 (ms_tick && close_cnt_reg != 16'h0) ? close_cnt_reg - 16'h1 : close_cnt_reg;
   wire [15:0] trip_cnt_next  = trip_load ? tpulse_ms_reg :
                 (ms_tick && trip_cnt_reg != 16'h0) ? trip_cnt_reg - 16'h1 : trip_cnt_reg;
   wire close_next = (close_fit & pins_s.pb_close & ~pb_close_blk)
                   | (close_cnt_next != 16'h0);
   wire trip_next  = (trip_fit & pins_s.pb_trip) | (trip_cnt_next != 16'h0);
   wire [31:0] il_cnt_next = trip_next ? il_ms_reg :
                 (ms_tick && il_active) ? il_cnt_reg - 32'h1 : il_cnt_reg;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pb_close_d_reg <= 1'b0;
         pb_trip_d_reg  <= 1'b0;
         close_cnt_reg  <= '0;
         trip_cnt_reg   <= '0;
         il_cnt_reg     <= '0;
         o_close_relay  <= 1'b0;
         o_trip_relay   <= 1'b0;
      end else begin
         pb_close_d_reg <= pins_s.pb_close;
         pb_trip_d_reg  <= pins_s.pb_trip;
         close_cnt_reg  <= close_cnt_next;
         trip_cnt_reg   <= trip_cnt_next;
         il_cnt_reg     <= il_cnt_next;
         o_close_relay  <= close_next;
         o_trip_relay   <= trip_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupts
   logic [IRQ_W-1:0] irq_evt;
   always_comb begin
      irq_evt                 = '0;
      irq_evt[IRQ_AUTO_TRIP]  = auto_trip;
      irq_evt[IRQ_AUTO_CLOSE] = auto_close;
      irq_evt[IRQ_RELEASE]    = (mode_reg != VOBC_REMOTE) & (mode_next == VOBC_REMOTE);
      irq_evt[IRQ_REM_REJ]    = (i_rcmd.trip | i_rcmd.close) & ~rem_ok;
      irq_evt[IRQ_CLOSE_BLK]  = (auto_close & il_active) | (i_rcmd.close & rem_ok & il_active)
                              | (pb_close_rise & pb_close_blk);
   end
   wire [IRQ_W-1:0] irq_clr       = wr_irq_st ? wr_data[IRQ_W-1:0] : '0;
   wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux and bus outputs
   logic [31:0] rd_data;
   logic        rd_hit;
   always_comb begin
      rd_data = '0;
      rd_hit  = 1'b1;
      unique case (i_axi_araddr)
         ADDR_CTRL:      rd_data = {30'h0, permit_reg, run_reg};
         ADDR_SWDLY:     rd_data = swdly_reg;
         ADDR_THR0:      rd_data = {16'h0, thr_reg[THR_TRIP]};
         ADDR_THR0 + 8'h04: rd_data = {16'h0, thr_reg[THR_TREL]};
         ADDR_THR0 + 8'h08: rd_data = {16'h0, thr_reg[THR_CREL]};
         ADDR_THR0 + 8'h0C: rd_data = {16'h0, thr_reg[THR_CLOSE]};
         ADDR_IL_MS:     rd_data = il_ms_reg;
         ADDR_CPULSE:    rd_data = {16'h0, cpulse_ms_reg};
         ADDR_TPULSE:    rd_data = {16'h0, tpulse_ms_reg};
         ADDR_STATUS:    rd_data = {26'h0, run_reg, o_trip_relay, o_close_relay, il_active, mode_reg};
         ADDR_IRQ_ST:    rd_data = {27'h0, irq_stat_reg};
         ADDR_IRQ_MK:    rd_data = {27'h0, irq_mask_reg};
         default:        rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         awready_reg  <= 1'b0;
         wready_reg   <= 1'b0;
         arready_reg  <= 1'b0;
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         bvalid_reg   <= 1'b0;
         rvalid_reg   <= 1'b0;
         awaddr_reg   <= '0;
         wdata_reg    <= '0;
         wstrb_reg    <= '0;
         bresp_reg    <= RESP_OKAY;
         rresp_reg    <= RESP_OKAY;
         rdata_reg    <= '0;
         irq_stat_reg <= '0;
         o_irq        <= 1'b0;
         o_mode       <= VOBC_REMOTE;
      end else begin
         awready_reg <= ~aw_got_next & ~bvalid_next;
         wready_reg  <= ~w_got_next & ~bvalid_next;
         arready_reg <= ~rvalid_next;
         aw_got_reg  <= aw_got_next;
         w_got_reg   <= w_got_next;
         bvalid_reg  <= bvalid_next;
         rvalid_reg  <= rvalid_next;
         if (aw_hs) awaddr_reg <= i_axi_awaddr;
         if (w_hs) wdata_reg <= i_axi_wdata;
         if (w_hs) wstrb_reg <= i_axi_wstrb;
         if (do_wr) bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (ar_hs) rdata_reg <= rd_data;
         if (ar_hs) rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         irq_stat_reg <= irq_stat_next;
         o_irq        <= |(irq_stat_next & irq_mask_reg);
         o_mode       <= mode_next;
      end
   end

   assign o_axi_awready = awready_reg;
   assign o_axi_wready  = wready_reg;
   assign o_axi_bvalid  = bvalid_reg;
   assign o_axi_bresp   = bresp_reg;
   assign o_axi_arready = arready_reg;
   assign o_axi_rvalid  = rvalid_reg;
   assign o_axi_rdata   = rdata_reg;
   assign o_axi_rresp   = rresp_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_trip_ends;
      $fell(o_trip_relay) ##0 (il_ms_reg != 32'h0);
   endsequence

   AST_IL_BLOCK: assert property (@(posedge i_core_clk) disable iff (i_rst)
      close_fit && pins_s.interlock_select_header && il_active && !close_load && close_cnt_reg == 0
      |=> !o_close_relay) else $error("close passed during interlock");
   AST_IL_DEFEAT: assert property (@(posedge i_core_clk) disable iff (i_rst)
      close_fit && pins_s.pb_close && !pins_s.interlock_select_header |=> o_close_relay)
      else $error("defeated interlock blocked close");
   AST_RAW_CLOSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !close_fit && close_cnt_reg == 0 && !close_load |=> !o_close_relay)
      else $error("raw close button reached relay");
   AST_TRIP_DIRECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
      trip_fit && pins_s.pb_trip |=> o_trip_relay) else $error("trip button not routed");
   AST_RAW_TRIP: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !trip_fit && trip_cnt_reg == 0 && !trip_load |=> !o_trip_relay)
      else $error("raw trip button reached relay");
   AST_IL_AFTER_TRIP: assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_trip_ends |-> $past(il_cnt_reg) == $past(il_ms_reg))
      else $error("interlock not started by trip");
   AST_OVR_OFF: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !run_reg |=> mode_reg == VOBC_REMOTE && !auto_trip && !auto_close)
      else $error("override active while disabled");
   AST_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      mode_reg != $past(mode_reg) && run_reg && $past(run_reg) |-> $past(dly_cnt_reg) > $past(swdly_reg))
      else $error("mode changed before delay");
   AST_RESTART: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rgn != rgn_reg |=> dly_cnt_reg == 0) else $error("timer kept on region change");
   AST_REM_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
      mode_reg != VOBC_REMOTE && i_rcmd.trip && !auto_trip && (trip_fit || !pb_trip_rise)
      && trip_cnt_reg == 0 && !(trip_fit && pins_s.pb_trip) |=> !o_trip_relay)
      else $error("remote trip executed outside REMOTE");
endmodule : vobc_top
`default_nettype wire

// ### rtl/vobc_pkg.sv
/*
 Constants, types and register map of the capacitor bank switching control.
 Assumes a 50 MHz core clock and an AXI4-Lite master with 32-bit data.
*/
// What this block does
// - Enforce header blocks close pushbutton during interlock
// - Defeat header lets close pushbutton bypass interlock
// - Close jumper fitted: pushbutton drives close relay
// - Close jumper absent: timed close pulse instead
// - Trip jumper fitted: pushbutton drives trip relay
// - Trip jumper absent: timed trip pulse instead
// - Every trip restarts the safety interlock timer
// - Manual operation ignores override and voltage
// - Permit bit gates remote override on/off codes
// - Run enable starts or stops override machine
// - Mode changes only after region held past delay, or to REMOTE at once when run is off
// - Thresholds are integers in tenths of volts
// - High voltage held: trip, enter TRIPPED mode
// - TRIPPED, below release held: enter REMOTE mode
// - CLOSED, above release held: enter REMOTE mode
// - Low voltage held: close unless interlock active, enter CLOSED mode
package vobc_pkg;

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SWDLY  = 8'h04;
   localparam logic [7:0] ADDR_THR0   = 8'h08;
   localparam logic [7:0] ADDR_IL_MS  = 8'h18;
   localparam logic [7:0] ADDR_CPULSE = 8'h1C;
   localparam logic [7:0] ADDR_TPULSE = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h28;
   localparam logic [7:0] ADDR_IRQ_MK = 8'h2C;

   // Threshold indexes, four words from ADDR_THR0
   localparam int unsigned THR_TRIP  = 0;
   localparam int unsigned THR_TREL  = 1;
   localparam int unsigned THR_CREL  = 2;
   localparam int unsigned THR_CLOSE = 3;

   // Control fields
   localparam int unsigned CTRL_RUN_BIT    = 0;
   localparam int unsigned CTRL_PERMIT_BIT = 1;

   // Interrupt fields
   localparam int unsigned IRQ_W          = 5;
   localparam int unsigned IRQ_AUTO_TRIP  = 0;
   localparam int unsigned IRQ_AUTO_CLOSE = 1;
   localparam int unsigned IRQ_RELEASE    = 2;
   localparam int unsigned IRQ_REM_REJ    = 3;
   localparam int unsigned IRQ_CLOSE_BLK  = 4;

   // Reset values
   localparam logic        RST_RUN     = 1'b0;
   localparam logic        RST_PERMIT  = 1'b0;
   localparam logic [31:0] RST_SWDLY   = 32'h0000EA60;
   localparam logic [15:0] RST_TRIP    = 16'h04F6;
   localparam logic [15:0] RST_TREL    = 16'h04D8;
   localparam logic [15:0] RST_CREL    = 16'h04B0;
   localparam logic [15:0] RST_CLOSE   = 16'h0492;
   localparam logic [31:0] RST_IL_MS   = 32'h000493E0;
   localparam logic [15:0] RST_CPULSE  = 16'h0064;
   localparam logic [15:0] RST_TPULSE  = 16'h0064;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      VOBC_REMOTE,
      VOBC_TRIPPED,
      VOBC_CLOSED
   } vobc_mode_t;

   typedef enum logic [1:0] {
      VOBC_RGN_NONE,
      VOBC_RGN_UP,
      VOBC_RGN_DOWN
   } vobc_rgn_t;

   // Remote command strobes, one cycle each
   typedef struct packed {
      logic trip;
      logic close;
      logic ovr_on;
      logic ovr_off;
   } vobc_rcmd_t;

   // Pushbuttons and jumpers, asynchronous levels
   localparam int unsigned PINS_W = 5;
   typedef struct packed {
      logic pb_close;
      logic pb_trip;
      logic interlock_select_header;
      logic local_close_source_select;
      logic local_trip_source_select;
   } vobc_pins_t;

endpackage : vobc_pkg

// ### rtl/vobc_sync.sv
/*
 Two flip-flop level synchroniser.
 Assumes inputs are slow levels from pins.
*/
`timescale 1ns/1ns
`default_nettype none
module vobc_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   // Levels
   input  wire logic [W-1:0] i_d,
   output var  logic [W-1:0] o_q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= i_d;
         s2_reg <= s1_reg;
      end
   end

   assign o_q = s2_reg;
endmodule : vobc_sync
`default_nettype wire

// ### testbench/vobc_far.sv
/* Far side model: pushbuttons, jumpers, remote command source.
 Assumes the block's core clock; calls start just after an edge. */
`timescale 1ns/1ns
`default_nettype none
module vobc_far (
   input  wire logic                 i_core_clk,
   output var  vobc_pkg::vobc_pins_t o_pins,
   output var  vobc_pkg::vobc_rcmd_t o_rcmd
);
   import vobc_pkg::*;
   initial o_pins = 5'h07;
   initial o_rcmd = 4'h0;
   task automatic press(input int b, input int n);
      o_pins[b] <= 1'b1;
      repeat (n) @(posedge i_core_clk);
      o_pins[b] <= 1'b0;
   endtask : press
   task automatic send(input logic [3:0] c);
      o_rcmd <= c;
      @(posedge i_core_clk);
      o_rcmd <= 4'h0;
   endtask : send
endmodule : vobc_far
`default_nettype wire

// ### testbench/tb.sv
/* Bench of the bank switching control.
 Assumes vobc_top with a 10 cycle millisecond. */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import vobc_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, brdy = 0, rrdy = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat;
   logic [15:0] volt = 0;
   logic [1:0] rsp;
   logic [15:0] vs [4] = '{16'h0514, 16'h04CE, 16'h044C, 16'h04BA};
   logic [1:0] ms [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
   wire logic awr, wrdy, bv, arr, rv, crel, trel, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire vobc_pins_t pins;
   wire vobc_rcmd_t rcmd;
   wire vobc_mode_t mode;
   int bad_count = 0, compares = 0, cyc = 0;
   always #10 clk = ~clk;
   vobc_far far (.i_core_clk(clk), .o_pins(pins), .o_rcmd(rcmd));
   vobc_top #(.P_CYC_PER_MS(10)) dut (.i_core_clk(clk), .i_rst(rst),
      .i_axi_awaddr(awa), .i_axi_awvalid(awv), .o_axi_awready(awr),
      .i_axi_wdata(wd), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv), .o_axi_wready(wrdy),
      .o_axi_bresp(bresp), .o_axi_bvalid(bv), .i_axi_bready(brdy),
      .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
      .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rv),
      .i_axi_rready(rrdy), .i_pins(pins), .i_line_volt(volt), .i_rcmd(rcmd),
      .o_close_relay(crel), .o_trip_relay(trel), .o_mode(mode), .o_irq(irq));
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : ck
   task automatic print_verdict;
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1;
      do begin @(posedge clk); if (awr) awv <= 0; if (wrdy) wv <= 0; end while (!bv);
      rsp = bresp;
      brdy <= 0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      ara <= a; arv <= 1; rrdy <= 1;
      do begin @(posedge clk); if (arr) arv <= 0; end while (!rv);
      rdat = rdata; rsp = rresp; rrdy <= 0;
      @(posedge clk);
   endtask : rd
   task automatic hold(input logic [15:0] v, input int n);
      volt <= v;
      repeat (n) @(posedge clk);
   endtask : hold
   task automatic t_reset;
      ck(mode, 0);
      rd(ADDR_SWDLY); ck(rdat, RST_SWDLY);
      rd(8'hF0); ck(rsp, RESP_SLVERR);
      wr(8'hF0, 0);
      ck(rsp, RESP_SLVERR);
      wr(ADDR_SWDLY, 3);
      ck(rsp, RESP_OKAY);
      wr(ADDR_IL_MS, 4); wr(ADDR_TPULSE, 3); wr(ADDR_CPULSE, 3);
   endtask : t_reset
   task automatic t_manual;
      far.press(3, 4); ck(trel, 1);
      repeat (10) @(posedge clk); far.press(4, 4); ck(crel, 0);
      repeat (60) @(posedge clk); far.press(4, 4); ck(crel, 1);
      far.o_pins[2] <= 0; far.press(3, 4); far.press(4, 4); ck(crel, 1);
   endtask : t_manual
   task automatic t_pulse;
      far.o_pins[2:0] <= 3'b100; repeat (60) @(posedge clk);
      far.press(3, 2); repeat (8) @(posedge clk); ck(trel, 1);
      repeat (40) @(posedge clk); ck(trel, 0);
      repeat (60) @(posedge clk); far.press(4, 2); repeat (8) @(posedge clk);
      ck(crel, 1);
   endtask : t_pulse
   task automatic t_override;
      wr(ADDR_CTRL, 1);
      foreach (vs[i]) begin
         hold(vs[i], 80);
         ck(mode, ms[i]);
         if (i == 0) begin
            far.send(4'h8);
            repeat (2) @(posedge clk);
            ck(trel, 0);
         end
         if (i == 1) begin
            far.send(4'h4);
            repeat (2) @(posedge clk);
            ck(crel, 1);
         end
      end
      rd(ADDR_IRQ_ST); ck(rdat[4:0], 5'h1F); ck(irq, 0);
      wr(ADDR_IRQ_MK, 1); ck(irq, 1); wr(ADDR_IRQ_ST, 32'h1F); ck(irq, 0);
      hold(16'h0514, 22); hold(16'h04E2, 1); hold(16'h0514, 22); ck(mode, 0);
      wr(ADDR_CTRL, 0); hold(16'h0514, 80); ck(mode, 0);
   endtask : t_override
   task automatic t_remote;
      far.send(4'h2); rd(ADDR_CTRL); ck(rdat[1:0], 0);
      wr(ADDR_CTRL, 2);
      far.send(4'h8);
      repeat (5) @(posedge clk);
      far.send(4'h4);
      repeat (2) @(posedge clk);
      ck(trel, 1);
      ck(crel, 0);
      far.send(4'h2); rd(ADDR_CTRL); ck(rdat[1:0], 3);
      far.send(4'h1); rd(ADDR_CTRL); ck(rdat[1:0], 2);
   endtask : t_remote
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      t_reset(); t_manual(); t_pulse(); t_override(); t_remote();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
